/* sccs_pkg.sv */
/*
 * sccs_pkg: constants, types and helpers of the system clock switcher.
 * Assumes a 10 MHz bus clock; oscillator sources arrive as plain pins.
 */
package sccs_pkg;

  // ****************************************************
  // oscillator modes, held in the configuration field
  // ****************************************************
  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL,
    CRYSTAL_RESONATOR,
    HIGH_SPEED_CRYSTAL,
    RESISTOR_CAPACITOR_CLKOUT,
    RESISTOR_CAPACITOR_PINFREE,
    INTERNAL_OSC_CLKOUT,
    INTERNAL_OSC_PINFREE,
    EXTERNAL_CLOCK_PINFREE
  } sccs_mode_t;

  // ****************************************************
  // clock source codes (system clock select values)
  // ****************************************************
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_SIDE = 2'h1;
  localparam logic [1:0] SEL_INTERNAL = 2'h2;

  // ****************************************************
  // register map and fields
  // ****************************************************
  localparam logic [11:0] TIMER_ONE_CONTROL_ADDR = 12'h010;
  localparam logic [11:0] OSC_CONTROL_ADDR = 12'h014;
  localparam int T1C_SIDE_RUNNING_BIT = 6;
  localparam int T1C_SIDE_OSC_EN_BIT = 3;
  localparam logic [5:0] T1C_RESET = 6'h00;
  localparam int OSC_SEL_LSB = 0;
  localparam int OSC_IFS_BIT = 2;
  localparam int OSC_PST_BIT = 3;
  localparam int OSC_FSEL_LSB = 4;
  localparam logic [1:0] OSC_SEL_RESET = 2'h0;
  localparam logic [2:0] OSC_FSEL_RESET = 3'h0;
  localparam logic [2:0] FSEL_SLOWEST = 3'h0;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] SYNC_EDGES = 11'h008;
  localparam logic [CNT_W-1:0] WARMUP_EDGES = 11'h400;
  localparam int CLK_PERIOD_NS = 100;
  localparam int INTERNAL_FREQ_STABLE_TIME_US = 4000;
  localparam int INTERNAL_FREQ_STABLE_CYCLES =
    (INTERNAL_FREQ_STABLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // crystal modes need the long warm-up count
  function automatic logic sccs_is_crystal(input logic [2:0] m);
    return m inside {LOW_POWER_CRYSTAL, CRYSTAL_RESONATOR,
                     HIGH_SPEED_CRYSTAL};
  endfunction : sccs_is_crystal

endpackage : sccs_pkg

/* sccs_cnt_if.sv */
/*
 * sccs_cnt_if: carries an edge-count request between the switcher
 * and its edge counter. Assumes both ends share the bus clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface sccs_cnt_if;
  logic start; // one-cycle request
  logic [10:0] limit; // edges to count
  logic edge_pls; // one source edge seen
  logic done; // one-cycle completion
  modport ctrl (output start, output limit, output edge_pls,
                input done);
  modport cnt (input start, input limit, input edge_pls,
               output done);
endinterface : sccs_cnt_if

`default_nettype wire

/* sccs_edge_counter.sv */
/*
 * sccs_edge_counter: counts oscillator edge pulses up to a limit.
 * Assumes edge pulses are already synchronised to hclk.
 */
`timescale 1ns/100ps
`default_nettype none

module sccs_edge_counter (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request side
  sccs_cnt_if.cnt cnt
);
  import sccs_pkg::*;

  logic [CNT_W-1:0] count_r; // edges seen so far
  logic busy_r; // a count is running
  logic done_r; // completion pulse

  // ****************************************************
  // counting
  // ****************************************************
  // a new start restarts the count; a late edge cannot leak in
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (cnt.start) begin
        count_r <= '0;
        busy_r <= 1'b1;
      end else if (busy_r && cnt.edge_pls) begin
        if (count_r + 11'h001 == cnt.limit) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        count_r <= count_r + 11'h001;
      end
    end
  end

  assign cnt.done = done_r;

endmodule : sccs_edge_counter

`default_nettype wire

/* sccs_switcher.sv */
/*
 * sccs_switcher: system clock source selection and switching, with
 * its registers on AHB-Lite. Assumes oscillator pins are asynchronous
 * to hclk and far slower than it; the mode field is static config.
 */
// Function
// - eight oscillator modes from three config bits
// - mode decides clock-out and freed pins
// - select internal: clear status, stop primary
// - no switch if primary already internal
// - freq-stable sets about 4 ms later; at once with the slowest frequency select
// - hold phase one for eight edges of the new source
// - cleared primary status means low-power run
// - to internal: 8 edges, flags 0/0
// - to side: 8 edges, side-running set
// - to external/RC primary: 8 edges, status set
// - to crystal: 1024 plus 8 edges
// - crystal reset: 1024 wait, two-speed option
// - internal frequency follows frequency select
// - side-running bit reflects side clock use
// - side enable runs the side oscillator
`timescale 1ns/100ps
`default_nettype none

module sccs_switcher #(
  parameter int INTERNAL_FREQ_STABLE_WAIT = sccs_pkg::INTERNAL_FREQ_STABLE_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // configuration
  input wire logic [2:0] osc_mode_config,
  input wire logic two_speed_enable,
  // oscillator pins
  input wire logic primary_osc_pin,
  input wire logic internal_osc_pin,
  input wire logic side_osc_pin,
  // clock control outputs
  output logic [1:0] sys_clk_source,
  output logic exec_enable,
  output logic phase_one_hold,
  output logic primary_osc_enable,
  output logic side_osc_enable,
  output logic [2:0] internal_freq_select,
  // pin use
  output logic clkout_enable,
  output logic osc_out_io_free,
  output logic osc_in_io_free
);
  import sccs_pkg::*;

  typedef enum logic [1:0] {ST_RST_OST, ST_IDLE, ST_WARM, ST_SYNC}
    sccs_state_t;

  sccs_cnt_if cnt_if ();

  sccs_state_t state_r; // switch sequencer state
  logic [1:0] cur_src_r; // source now clocking the core
  logic [1:0] tgt_src_r; // source being switched to
  logic [1:0] clk_src_r; // source driven out
  logic ost_arm_r; // first cycle after reset
  logic primary_status_r; // primary clock in use
  logic internal_freq_stable_r; // internal frequency stable
  logic [15:0] internal_freq_stable_cnt_r; // stabilisation timer
  logic internal_freq_stable_run_r; // stabilisation timer running
  logic prim_en_r; // primary oscillator powered
  logic [5:0] t1c_r; // writable timer control bits
  logic [1:0] sel_r; // system clock select
  logic [2:0] fsel_r; // internal frequency select
  logic [2:0] sync1_r, sync2_r, sync3_r; // pin synchronisers
  logic [2:0] fall; // falling edge pulses
  logic wr_pend_r; // write data phase due
  logic [11:0] addr_r; // latched write address
  logic [31:0] hrdata_r; // read data
  logic [2:0] mode; // oscillator mode
  logic crystal; // crystal mode
  logic mode_internal; // primary is internal oscillator
  logic [1:0] want_src; // source the select asks for
  logic go_switch; // start a switch this cycle
  logic side_running; // side oscillator clocks core
  logic prim_fall; // edge of the primary source

  // ****************************************************
  // pin synchronisers and edge detect
  // ****************************************************
  // the first stage feeds only the second, to keep metastability out
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          sync3_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= (g == 0) ? primary_osc_pin :
                        (g == 1) ? internal_osc_pin : side_osc_pin;
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
        end
      end
      assign fall[g] = sync3_r[g] & ~sync2_r[g];
    end
  endgenerate

  // ****************************************************
  // mode decode
  // ****************************************************
  assign mode = osc_mode_config;
  assign crystal = sccs_is_crystal(mode);
  assign mode_internal = mode inside {INTERNAL_OSC_CLKOUT,
                                      INTERNAL_OSC_PINFREE};
  // internal modes have no pin oscillator; the internal one stands in
  assign prim_fall = mode_internal ? fall[1] : fall[0];

  // pin use per mode
  assign clkout_enable = mode inside {RESISTOR_CAPACITOR_CLKOUT,
                                      INTERNAL_OSC_CLKOUT};
  assign osc_out_io_free = mode inside {RESISTOR_CAPACITOR_PINFREE,
    INTERNAL_OSC_PINFREE, EXTERNAL_CLOCK_PINFREE};
  assign osc_in_io_free = mode_internal;

  // ****************************************************
  // switch request
  // ****************************************************
  // the select is a level; a write that changes it starts a switch
  assign want_src = sel_r[1] ? SEL_INTERNAL : sel_r;
  assign go_switch = (state_r == ST_IDLE) && (want_src != cur_src_r) &&
    !(want_src == SEL_INTERNAL && cur_src_r == SEL_PRIMARY &&
      mode_internal);

  assign cnt_if.start = (ost_arm_r && crystal) || go_switch ||
                        (state_r == ST_WARM && cnt_if.done);
  // compared on every edge, so the limit follows the state, not the start
  assign cnt_if.limit = (state_r == ST_RST_OST || state_r == ST_WARM) ?
    WARMUP_EDGES : SYNC_EDGES;
  assign cnt_if.edge_pls = (tgt_src_r == SEL_INTERNAL) ? fall[1] :
                           (tgt_src_r == SEL_SIDE) ? fall[2] : prim_fall;

  sccs_edge_counter u_cnt (
    .hclk (hclk),
    .hresetn (hresetn),
    .cnt (cnt_if.cnt)
  );

  // ****************************************************
  // switch sequencer
  // ****************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_RST_OST;
      cur_src_r <= SEL_PRIMARY;
      tgt_src_r <= SEL_PRIMARY;
      clk_src_r <= SEL_PRIMARY;
      ost_arm_r <= 1'b1;
      primary_status_r <= 1'b0;
      prim_en_r <= 1'b1;
    end else begin
      ost_arm_r <= 1'b0;
      unique case (state_r)
        ST_RST_OST: begin
          // no switch sequence at reset; two-speed runs on internal
          clk_src_r <= (crystal && two_speed_enable) ? SEL_INTERNAL :
                       SEL_PRIMARY;
          if (!crystal || cnt_if.done) begin
            state_r <= ST_IDLE;
            clk_src_r <= SEL_PRIMARY;
            primary_status_r <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (go_switch) begin
            tgt_src_r <= want_src;
            if (want_src == SEL_PRIMARY) begin
              prim_en_r <= 1'b1;
              state_r <= crystal ? ST_WARM : ST_SYNC;
            end else begin
              // status drops at once: core leaves the primary
              primary_status_r <= 1'b0;
              if (want_src == SEL_INTERNAL) begin
                prim_en_r <= 1'b0;
              end
              state_r <= ST_SYNC;
            end
          end
        end
        ST_WARM: begin
          // execution continues on the old source meanwhile
          if (cnt_if.done) begin
            state_r <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          clk_src_r <= tgt_src_r;
          if (cnt_if.done) begin
            state_r <= ST_IDLE;
            cur_src_r <= tgt_src_r;
            primary_status_r <= (tgt_src_r == SEL_PRIMARY);
          end
        end
      endcase
    end
  end

  // core held in phase one while the new clock settles
  assign phase_one_hold = (state_r == ST_SYNC);
  assign exec_enable = !((state_r == ST_RST_OST) && crystal &&
                         !two_speed_enable);
  assign sys_clk_source = clk_src_r;
  assign primary_osc_enable = prim_en_r;
  assign side_running = (cur_src_r == SEL_SIDE);
  // the side oscillator inverter is off unless enabled
  assign side_osc_enable = t1c_r[T1C_SIDE_OSC_EN_BIT];
  assign internal_freq_select = fsel_r;

  // ****************************************************
  // internal frequency stable flag
  // ****************************************************
  // slowest setting needs no settling; faster ones wait the timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_freq_stable_r <= 1'b0;
      internal_freq_stable_run_r <= 1'b0;
      internal_freq_stable_cnt_r <= '0;
    end else if (go_switch && want_src == SEL_INTERNAL) begin
      internal_freq_stable_r <= (fsel_r == FSEL_SLOWEST);
      internal_freq_stable_run_r <= (fsel_r != FSEL_SLOWEST);
      internal_freq_stable_cnt_r <= '0;
    end else if (internal_freq_stable_run_r) begin
      internal_freq_stable_cnt_r <= internal_freq_stable_cnt_r + 16'h0001;
      if (internal_freq_stable_cnt_r == 16'(INTERNAL_FREQ_STABLE_WAIT - 1)) begin
        internal_freq_stable_run_r <= 1'b0;
        internal_freq_stable_r <= 1'b1;
      end
    end else if (cur_src_r != SEL_INTERNAL && state_r == ST_IDLE) begin
      internal_freq_stable_r <= 1'b0;
    end
  end

  // ****************************************************
  // ahb-lite slave
  // ****************************************************
  // zero wait states: every transfer completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // address phase: latch writes, fetch read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= '0;
      hrdata_r <= '0;
    end else begin
      wr_pend_r <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) begin
        addr_r <= haddr[11:0];
        hrdata_r <= '0; // unmapped reads as zero
        if (!hwrite && haddr[11:0] == TIMER_ONE_CONTROL_ADDR) begin
          hrdata_r[5:0] <= t1c_r;
          hrdata_r[T1C_SIDE_RUNNING_BIT] <= side_running;
        end else if (!hwrite && haddr[11:0] == OSC_CONTROL_ADDR) begin
          hrdata_r[OSC_SEL_LSB +: 2] <= sel_r;
          hrdata_r[OSC_IFS_BIT] <= internal_freq_stable_r;
          hrdata_r[OSC_PST_BIT] <= primary_status_r;
          hrdata_r[OSC_FSEL_LSB +: 3] <= fsel_r;
        end
      end
    end
  end

  // data phase: update writable fields only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1c_r <= T1C_RESET;
      sel_r <= OSC_SEL_RESET;
      fsel_r <= OSC_FSEL_RESET;
    end else if (wr_pend_r) begin
      if (addr_r == TIMER_ONE_CONTROL_ADDR) begin
        t1c_r <= hwdata[5:0];
      end else if (addr_r == OSC_CONTROL_ADDR) begin
        sel_r <= hwdata[OSC_SEL_LSB +: 2];
        fsel_r <= hwdata[OSC_FSEL_LSB +: 3];
      end
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_INT_DROPS: assert property (go_switch && want_src == SEL_INTERNAL
    |=> !primary_status_r && !prim_en_r)
    else $error("primary not dropped on internal switch");
  AST_NO_SWITCH: assert property (state_r == ST_IDLE && mode_internal &&
    cur_src_r == SEL_PRIMARY && want_src == SEL_INTERNAL
    |=> state_r == ST_IDLE)
    else $error("switch to internal when already internal");
  AST_INTERNAL_FREQ_STABLE_SET: assert property (internal_freq_stable_run_r &&
    internal_freq_stable_cnt_r == 16'(INTERNAL_FREQ_STABLE_WAIT - 1) |=> internal_freq_stable_r)
    else $error("frequency stable flag late");
  AST_RELEASE: assert property (state_r == ST_SYNC && cnt_if.done
    |=> !phase_one_hold ##0 state_r == ST_IDLE)
    else $error("phase hold not released");
  AST_TO_INT: assert property (state_r == ST_SYNC && cnt_if.done &&
    tgt_src_r == SEL_INTERNAL
    |=> !primary_status_r && !side_running)
    else $error("bad flags after internal switch");
  AST_TO_SIDE: assert property (state_r == ST_SYNC && cnt_if.done &&
    tgt_src_r == SEL_SIDE |=> side_running && !primary_status_r)
    else $error("bad flags after side switch");
  AST_TO_PRIM: assert property (state_r == ST_SYNC && cnt_if.done &&
    tgt_src_r == SEL_PRIMARY
    |=> primary_status_r && !side_running)
    else $error("bad flags after primary switch");
  AST_WARM_RUNS: assert property (state_r == ST_WARM
    |-> exec_enable && !phase_one_hold && !primary_status_r)
    else $error("execution stopped during warm-up");
  AST_OST: assert property (state_r == ST_RST_OST && crystal
    |-> exec_enable == two_speed_enable)
    else $error("reset start-up execution wrong");
  AST_PINS: assert property (mode == INTERNAL_OSC_PINFREE
    |-> osc_out_io_free && osc_in_io_free && !clkout_enable)
    else $error("pin use wrong in internal pin-free mode");

  COV_INT: cover property (state_r == ST_SYNC && cnt_if.done &&
    tgt_src_r == SEL_INTERNAL);
  COV_SIDE: cover property (state_r == ST_SYNC && cnt_if.done &&
    tgt_src_r == SEL_SIDE);
  COV_WARM: cover property (state_r == ST_WARM && cnt_if.done);

endmodule : sccs_switcher

`default_nettype wire

/* sccs_switcher_tb_top.sv */
/*
 * sccs_switcher_tb_top: self-checking bench for the clock switcher.
 * Assumes the design files come first; oscillator pins run free.
 */
`timescale 1ns/100ps
`default_nettype none

module sccs_switcher_tb_top;
  import sccs_pkg::*;
  // ****************************************************
  // wiring and bench state
  // ****************************************************
  logic hclk, hresetn, hsel, hwrite, two_speed_enable;
  logic [31:0] haddr, hwdata, hrdata, rd, rv;
  logic [1:0] htrans, sys_clk_source;
  logic [2:0] hsize, osc_mode_config, internal_freq_select, f;
  logic hreadyout, hresp, exec_enable, phase_one_hold;
  logic primary_osc_enable, side_osc_enable;
  logic clkout_enable, osc_out_io_free, osc_in_io_free;
  logic [2:0] pins; // primary, internal, side levels
  int cnt [3]; // half-period counters
  int mismatches, n_compared, n;
  localparam logic [31:0] TA = {20'h0, TIMER_ONE_CONTROL_ADDR};
  localparam logic [31:0] OA = {20'h0, OSC_CONTROL_ADDR};

  // clock of 100 ns
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // oscillators: half periods of 2, 3 and 4 hclk, all distinct
  always @(posedge hclk) begin
    for (int i = 0; i < 3; i++) begin
      if (cnt[i] >= i + 1) begin
        cnt[i] <= 0;
        pins[i] <= ~pins[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end

  sccs_switcher #(.INTERNAL_FREQ_STABLE_WAIT(200)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .osc_mode_config(osc_mode_config),
    .two_speed_enable(two_speed_enable), .primary_osc_pin(pins[0]),
    .internal_osc_pin(pins[1]), .side_osc_pin(pins[2]),
    .sys_clk_source(sys_clk_source), .exec_enable(exec_enable),
    .phase_one_hold(phase_one_hold),
    .primary_osc_enable(primary_osc_enable),
    .side_osc_enable(side_osc_enable),
    .internal_freq_select(internal_freq_select),
    .clkout_enable(clkout_enable), .osc_out_io_free(osc_out_io_free),
    .osc_in_io_free(osc_in_io_free)
  );

  // ****************************************************
  // expectations
  // ****************************************************
  // control word: select, stable, primary status, freq select
  function automatic logic [31:0] osc_w(input logic [1:0] s,
      input logic ifs, input logic pst, input logic [2:0] fs);
    return {25'h0, fs, pst, ifs, s};
  endfunction : osc_w

  // clock-out, osc-out freed, osc-in freed for a mode code
  function automatic logic [2:0] pin_w(input logic [2:0] m);
    return {m == 3'h3 || m == 3'h5, m == 3'h4 || m >= 3'h6,
            m == 3'h5 || m == 3'h6};
  endfunction : pin_w

  // ****************************************************
  // checks and bus cycles
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // cycle counts only need to land inside a window
  task automatic chk_in(input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask : chk_in

  // one single-word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask : bus

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rdc

  task automatic rst(input logic [2:0] m, input logic ts);
    hresetn <= 1'b0;
    osc_mode_config <= m;
    two_speed_enable <= ts;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : rst

  // counts on in n until the phase-one hold has come and gone
  task automatic hold_wait;
    while (phase_one_hold !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    while (phase_one_hold === 1'b1) begin
      @(posedge hclk);
      n++;
    end
    repeat (2) @(posedge hclk);
  endtask : hold_wait

  task automatic sw(input logic [1:0] s, input logic [2:0] fs);
    bus(1'b1, OA, osc_w(s, 1'b0, 1'b0, fs), rd);
    n = 0;
    hold_wait();
  endtask : sw

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    osc_mode_config = 3'h7;
    two_speed_enable = 1'b0;
    pins = 3'h0;
    cnt = '{0, 0, 0};
    mismatches = 0;
    n_compared = 0;
    rv = $urandom(65830);
    // pin use of every mode; reset between, the mode is static
    for (int m = 0; m < 8; m++) begin
      rst(3'(m), 1'b0);
      chk({29'h0, clkout_enable, osc_out_io_free, osc_in_io_free},
          {29'h0, pin_w(3'(m))});
    end
    done("modes");
    rst(EXTERNAL_CLOCK_PINFREE, 1'b0);
    rdc(TA, 32'h0);
    rdc(OA, osc_w(SEL_PRIMARY, 1'b0, 1'b1, 3'h0));
    // random timer value; bit 6 is read-only, bit 7 reads 0
    rv = $urandom;
    bus(1'b1, TA, rv, rd);
    rdc(TA, {26'h0, rv[5:0]});
    chk({31'h0, side_osc_enable}, {31'h0, rv[3]});
    bus(1'b1, 32'h40, 32'hFFFFFFFF, rd);
    rdc(32'h40, 32'h0);
    rdc(TA, {26'h0, rv[5:0]});
    done("registers");
    // to internal with a random non-zero frequency select
    f = 3'($urandom_range(7, 1));
    sw(SEL_INTERNAL, f);
    chk_in(n, 43, 62);
    chk({30'h0, sys_clk_source}, {30'h0, SEL_INTERNAL});
    chk({31'h0, primary_osc_enable}, 32'h0);
    chk({29'h0, internal_freq_select}, {29'h0, f});
    rdc(OA, osc_w(SEL_INTERNAL, 1'b0, 1'b0, f));
    repeat (200) @(posedge hclk);
    rdc(OA, osc_w(SEL_INTERNAL, 1'b1, 1'b0, f));
    done("internal");
    // side enable must be set before asking for the side clock
    bus(1'b1, TA, 32'h08, rd);
    // the write lands at the edge that ends its data phase
    @(posedge hclk);
    chk({31'h0, side_osc_enable}, 32'h1);
    sw(SEL_SIDE, f);
    chk_in(n, 57, 78);
    rdc(TA, 32'h48);
    rdc(OA, osc_w(SEL_SIDE, 1'b0, 1'b0, f));
    sw(SEL_PRIMARY, f);
    chk_in(n, 29, 46);
    chk({30'h0, sys_clk_source}, 32'h0);
    rdc(TA, 32'h08);
    rdc(OA, osc_w(SEL_PRIMARY, 1'b0, 1'b1, f));
    done("side and back");
    // internal as primary: asking for internal changes nothing
    rst(INTERNAL_OSC_PINFREE, 1'b0);
    bus(1'b1, OA, osc_w(SEL_INTERNAL, 1'b0, 1'b0, 3'h0), rd);
    repeat (40) @(posedge hclk);
    chk({31'h0, phase_one_hold}, 32'h0);
    chk({30'h0, sys_clk_source}, 32'h0);
    done("no switch");
    // crystal reset: execution held for the warm-up count
    rst(CRYSTAL_RESONATOR, 1'b0);
    chk({31'h0, exec_enable}, 32'h0);
    n = 2;
    while (exec_enable !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    chk_in(n, 4093, 4110);
    rdc(OA, osc_w(SEL_PRIMARY, 1'b0, 1'b1, 3'h0));
    // two-speed: internal clocks the device during warm-up
    rst(HIGH_SPEED_CRYSTAL, 1'b1);
    chk({31'h0, exec_enable}, 32'h1);
    chk({30'h0, sys_clk_source}, {30'h0, SEL_INTERNAL});
    while (sys_clk_source !== SEL_PRIMARY) @(posedge hclk);
    done("crystal reset");
    sw(SEL_INTERNAL, FSEL_SLOWEST);
    rdc(OA, osc_w(SEL_INTERNAL, 1'b1, 1'b0, 3'h0));
    bus(1'b1, OA, osc_w(SEL_PRIMARY, 1'b0, 1'b0, 3'h0), rd);
    repeat (100) @(posedge hclk);
    chk({30'h0, sys_clk_source}, {30'h0, SEL_INTERNAL});
    n = 100;
    hold_wait();
    chk_in(n, 4120, 4150);
    rdc(OA, osc_w(SEL_PRIMARY, 1'b0, 1'b1, 3'h0));
    done("crystal switch");
    conclude();
  end

  // watchdog well beyond the expected run of about 13000 cycles
  initial begin
    repeat (40000) @(posedge hclk);
    mismatches++;
    conclude();
  end
endmodule : sccs_switcher_tb_top

`default_nettype wire
